// file: fpp_pkg.sv
// package for the fuse prom programming sequencer
// assumes a 20 MHz system clock; all times become cycle counts here
package fpp_pkg;
  localparam int CLK_HZ         = 20_000_000;
  localparam int ADDR_W         = 9;
  localparam int DATA_W         = 8;
  localparam int WORDS          = 512;
  // edge spacing: above 100 ns, kept well under 1 us
  localparam int EDGE_MIN_NS    = 100;
  localparam int EDGE_CYC       = (EDGE_MIN_NS * (CLK_HZ / 1_000_000)
                                   + 999) / 1000 + 1;
  localparam int FIRST_PULSE_US = 50;
  localparam int FIRST_CYC      = FIRST_PULSE_US * (CLK_HZ / 1_000_000);
  localparam int RETRY_PULSE_MS = 5;
  localparam int RETRY_CYC      = RETRY_PULSE_MS * (CLK_HZ / 1000);
  localparam int LINK_LIMIT_MS  = 400;
  localparam int LINK_LIMIT_CYC = LINK_LIMIT_MS * (CLK_HZ / 1000);
  localparam int BURST_S        = 5;
  localparam int BURST_CYC      = BURST_S * CLK_HZ;
  localparam int CNT_W          = 27;

  typedef enum logic [10:0] {
    FPP_IDLE    = 11'h001,
    FPP_FETCH   = 11'h002,
    FPP_SCAN    = 11'h004,
    FPP_DESEL   = 11'h008,
    FPP_VOUT    = 11'h010,
    FPP_PULSE   = 11'h020,
    FPP_VOFF    = 11'h040,
    FPP_SENSE   = 11'h080,
    FPP_COOL    = 11'h100,
    FPP_VERIFY  = 11'h200,
    FPP_DONE    = 11'h400
  } fpp_state_e;

  // pins toward the prom
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic              cs_n;
    logic              cs_hv;
    logic              pwr_on;
    logic              vop_en;
    logic [DATA_W-1:0] vop_sel;
  } fpp_pins_s;

  // result toward the user
  typedef struct packed {
    logic              busy;
    logic              done;
    logic              fail_link;
    logic              fail_verify;
    logic [ADDR_W-1:0] fail_addr;
  } fpp_stat_s;
endpackage

// file: fpp_pattern_mem.sv
// holds the intended pattern, 512 words of 8 bits
// assumes one clock; read data appear one cycle after the address
`timescale 1ns/1ns
`default_nettype none
module fpp_pattern_mem #(
  parameter int AW = 9,
  parameter int DW = 8
) (
  input  wire logic          clk_sys,
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [DW-1:0] wr_data,
  input  wire logic [AW-1:0] rd_addr,
  output logic      [DW-1:0] rd_data
);
  logic [DW-1:0] mem [2**AW];

  always_ff @(posedge clk_sys) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule
`default_nettype wire

// file: fpp_ctrl.sv
// sequencer that blows fuses of a 512 x 8 fuse prom and verifies it
// assumes 20 MHz clk_sys, asynchronous rst, prom data pins from outside
`timescale 1ns/1ns
`default_nettype none
module fpp_ctrl #(
  parameter int FIRST_CYC = fpp_pkg::FIRST_CYC,
  parameter int RETRY_CYC = fpp_pkg::RETRY_CYC,
  parameter int LIMIT_CYC = fpp_pkg::LINK_LIMIT_CYC,
  parameter int BURST_CYC = fpp_pkg::BURST_CYC
) (
  input  wire logic                      clk_sys,
  input  wire logic                      rst,
  input  wire logic                      pat_wr,
  input  wire logic [fpp_pkg::ADDR_W-1:0] pat_addr,
  input  wire logic [fpp_pkg::DATA_W-1:0] pat_data,
  input  wire logic                      start,
  input  wire logic [fpp_pkg::DATA_W-1:0] prom_data,
  output fpp_pkg::fpp_pins_s             pins,
  output fpp_pkg::fpp_stat_s             stat
);
  localparam int AW = fpp_pkg::ADDR_W;
  localparam int DW = fpp_pkg::DATA_W;
  localparam int CW = fpp_pkg::CNT_W;

  // three-stage sampling of prom outputs
  logic [DW-1:0] s1_r, s2_r, s3_r, din_r;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s1_r  <= '0;
      s2_r  <= '0;
      s3_r  <= '0;
      din_r <= '0;
    end else begin
      s1_r <= prom_data;
      s2_r <= s1_r;
      s3_r <= s2_r;
      din_r <= (s2_r == s3_r) ? s3_r : din_r;
    end
  end

  logic [AW-1:0] addr_r, addr_nxt;
  logic [DW-1:0] pat;

  fpp_pattern_mem #(.AW(AW), .DW(DW)) u_mem (
    .clk_sys (clk_sys),
    .wr_en   (pat_wr),
    .wr_addr (pat_addr),
    .wr_data (pat_data),
    .rd_addr (addr_r),
    .rd_data (pat)
  );

  fpp_pkg::fpp_state_e st_r, st_nxt;
  logic [2:0]    bit_r, bit_nxt;
  logic [CW-1:0] tmr_r, tmr_nxt;
  logic [CW-1:0] link_r, link_nxt;
  logic [CW-1:0] burst_r, burst_nxt;
  logic          retry_r, retry_nxt;
  logic          vfy_r, vfy_nxt;
  fpp_pkg::fpp_pins_s pins_r, pins_nxt;
  fpp_pkg::fpp_stat_s stat_r, stat_nxt;

  logic          tmr_done;
  logic [CW-1:0] pulse_len;
  logic [DW-1:0] onehot;
  // edge spacing covers the three-flop sampling latency too
  localparam logic [CW-1:0] EDGE = CW'(fpp_pkg::EDGE_CYC + 3);

  assign tmr_done  = (tmr_r == '0);
  assign pulse_len = retry_r ? CW'(RETRY_CYC) : CW'(FIRST_CYC);
  assign onehot    = DW'(1) << bit_r;

  always_comb begin
    st_nxt    = st_r;
    addr_nxt  = addr_r;
    bit_nxt   = bit_r;
    tmr_nxt   = tmr_done ? tmr_r : tmr_r - CW'(1);
    link_nxt  = link_r;
    burst_nxt = burst_r;
    retry_nxt = retry_r;
    vfy_nxt   = vfy_r;
    pins_nxt  = pins_r;
    stat_nxt  = stat_r;
    stat_nxt.done = 1'b0;
    unique case (st_r)
      fpp_pkg::FPP_IDLE: begin
        pins_nxt.cs_n   = 1'b1;
        pins_nxt.cs_hv  = 1'b0;
        pins_nxt.vop_en = 1'b0;
        if (start) begin
          st_nxt        = fpp_pkg::FPP_FETCH;
          addr_nxt      = '0;
          bit_nxt       = '0;
          burst_nxt     = '0;
          stat_nxt      = '0;
          stat_nxt.busy = 1'b1;
          pins_nxt.pwr_on = 1'b1;
          pins_nxt.addr = '0;
          tmr_nxt       = EDGE;
        end
      end
      fpp_pkg::FPP_FETCH: begin
        // pattern word arrives one cycle after the address
        if (tmr_done) begin
          st_nxt = fpp_pkg::FPP_SCAN;
        end
      end
      fpp_pkg::FPP_SCAN: begin
        if (pat[bit_r]) begin
          st_nxt        = fpp_pkg::FPP_DESEL;
          pins_nxt.cs_n = 1'b1;
          retry_nxt     = 1'b0;
          link_nxt      = '0;
          tmr_nxt       = EDGE;
        end else if (bit_r != 3'h7) begin
          bit_nxt = bit_r + 3'h1;
        end else if (addr_r != AW'(fpp_pkg::WORDS - 1)) begin
          bit_nxt       = '0;
          addr_nxt      = addr_r + AW'(1);
          pins_nxt.addr = addr_r + AW'(1);
          tmr_nxt       = EDGE;
          st_nxt        = fpp_pkg::FPP_FETCH;
        end else begin
          st_nxt        = fpp_pkg::FPP_VERIFY;
          vfy_nxt       = 1'b0;
          addr_nxt      = '0;
          pins_nxt.addr = '0;
          pins_nxt.cs_n = 1'b0;
          tmr_nxt       = EDGE;
        end
      end
      fpp_pkg::FPP_DESEL: begin
        if (tmr_done) begin
          st_nxt           = fpp_pkg::FPP_VOUT;
          pins_nxt.vop_sel = onehot;
          pins_nxt.vop_en  = 1'b1;
          tmr_nxt          = EDGE;
        end
      end
      fpp_pkg::FPP_VOUT: begin
        if (tmr_done) begin
          st_nxt         = fpp_pkg::FPP_PULSE;
          pins_nxt.cs_hv = 1'b1;
          tmr_nxt        = pulse_len;
        end
      end
      fpp_pkg::FPP_PULSE: begin
        if (tmr_done) begin
          st_nxt          = fpp_pkg::FPP_VOFF;
          pins_nxt.cs_hv  = 1'b0;
          pins_nxt.vop_en = 1'b0;
          link_nxt        = link_r + pulse_len;
          burst_nxt       = burst_r + pulse_len;
          tmr_nxt         = EDGE;
        end
      end
      fpp_pkg::FPP_VOFF: begin
        if (tmr_done) begin
          st_nxt        = fpp_pkg::FPP_SENSE;
          pins_nxt.cs_n = 1'b0;
          tmr_nxt       = EDGE;
        end
      end
      fpp_pkg::FPP_SENSE: begin
        if (tmr_done) begin
          pins_nxt.cs_n = 1'b1;
          tmr_nxt       = EDGE;
          if (din_r[bit_r]) begin
            st_nxt  = fpp_pkg::FPP_SCAN;
            bit_nxt = bit_r + 3'h1;
            if (bit_r == 3'h7) begin
              // last bit of the word: move on, never rescan it
              pins_nxt.vop_sel = '0;
              bit_nxt          = '0;
              if (addr_r != AW'(fpp_pkg::WORDS - 1)) begin
                st_nxt        = fpp_pkg::FPP_FETCH;
                addr_nxt      = addr_r + AW'(1);
                pins_nxt.addr = addr_r + AW'(1);
              end else begin
                st_nxt        = fpp_pkg::FPP_VERIFY;
                vfy_nxt       = 1'b0;
                addr_nxt      = '0;
                pins_nxt.addr = '0;
                pins_nxt.cs_n = 1'b0;
              end
            end
          end else if (link_r >= CW'(LIMIT_CYC)) begin
            st_nxt             = fpp_pkg::FPP_DONE;
            stat_nxt.fail_link = 1'b1;
            stat_nxt.fail_addr = addr_r;
          end else if (burst_r >= CW'(BURST_CYC)) begin
            st_nxt          = fpp_pkg::FPP_COOL;
            pins_nxt.pwr_on = 1'b0;
            tmr_nxt         = CW'(BURST_CYC);
          end else begin
            st_nxt    = fpp_pkg::FPP_DESEL;
            retry_nxt = 1'b1;
          end
        end
      end
      fpp_pkg::FPP_COOL: begin
        if (tmr_done) begin
          pins_nxt.pwr_on = 1'b1;
          burst_nxt       = '0;
          retry_nxt       = 1'b1;
          tmr_nxt         = EDGE;
          st_nxt          = fpp_pkg::FPP_DESEL;
        end
      end
      fpp_pkg::FPP_VERIFY: begin
        if (tmr_done && !vfy_r) begin
          vfy_nxt = 1'b1;
          if (din_r != pat) begin
            stat_nxt.fail_verify = 1'b1;
            stat_nxt.fail_addr   = addr_r;
          end
        end else if (vfy_r) begin
          vfy_nxt = 1'b0;
          if (addr_r == AW'(fpp_pkg::WORDS - 1)) begin
            st_nxt        = fpp_pkg::FPP_DONE;
            pins_nxt.cs_n = 1'b1;
          end else begin
            addr_nxt      = addr_r + AW'(1);
            pins_nxt.addr = addr_r + AW'(1);
            tmr_nxt       = EDGE;
          end
        end
      end
      fpp_pkg::FPP_DONE: begin
        pins_nxt.cs_n   = 1'b1;
        pins_nxt.cs_hv  = 1'b0;
        pins_nxt.vop_en = 1'b0;
        stat_nxt.busy   = 1'b0;
        stat_nxt.done   = 1'b1;
        st_nxt          = fpp_pkg::FPP_IDLE;
      end
      default: begin
        st_nxt = fpp_pkg::FPP_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_r    <= fpp_pkg::FPP_IDLE;
      addr_r  <= '0;
      bit_r   <= '0;
      tmr_r   <= '0;
      link_r  <= '0;
      burst_r <= '0;
      retry_r <= 1'b0;
      vfy_r   <= 1'b0;
      pins_r  <= '{addr: '0, cs_n: 1'b1, cs_hv: 1'b0, pwr_on: 1'b0,
                   vop_en: 1'b0, vop_sel: '0};
      stat_r  <= '0;
    end else begin
      st_r    <= st_nxt;
      addr_r  <= addr_nxt;
      bit_r   <= bit_nxt;
      tmr_r   <= tmr_nxt;
      link_r  <= link_nxt;
      burst_r <= burst_nxt;
      retry_r <= retry_nxt;
      vfy_r   <= vfy_nxt;
      pins_r  <= pins_nxt;
      stat_r  <= stat_nxt;
    end
  end

  assign pins = pins_r;
  assign stat = stat_r;
endmodule
`default_nettype wire

// file: fpp_ctrl_sva.sv
// checker for the fuse prom sequencer pins and status
// assumes the ports of fpp_ctrl, bound from the testbench top
`timescale 1ns/1ns
`default_nettype none
module fpp_ctrl_sva (
  input wire logic                        clk_sys,
  input wire logic                        rst,
  input wire logic                        pat_wr,
  input wire logic [fpp_pkg::ADDR_W-1:0]  pat_addr,
  input wire logic [fpp_pkg::DATA_W-1:0]  pat_data,
  input wire logic                        start,
  input wire logic [fpp_pkg::DATA_W-1:0]  prom_data,
  input wire fpp_pkg::fpp_pins_s          pins,
  input wire fpp_pkg::fpp_stat_s          stat
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence s_desel;
    pins.cs_n && !pins.cs_hv;
  endsequence
  sequence s_pulse;
    pins.cs_hv [*8];
  endsequence
  property p_desel_first;
    $rose(pins.vop_en) |-> s_desel ##0 $past(pins.cs_n);
  endproperty
  a_desel_first: assert property (p_desel_first)
    else $error("supply applied while selected");
  property p_hv_gated;
    pins.cs_hv |-> pins.cs_n && pins.vop_en && pins.pwr_on;
  endproperty
  a_hv_gated: assert property (p_hv_gated)
    else $error("programming level without supply");
  property p_pulse_min;
    $rose(pins.cs_hv) |-> s_pulse;
  endproperty
  a_pulse_min: assert property (p_pulse_min)
    else $error("programming pulse too short");
  property p_supply_ahead;
    $rose(pins.cs_hv) |-> $past(pins.vop_en, 2);
  endproperty
  a_supply_ahead: assert property (p_supply_ahead)
    else $error("edge spacing before pulse too short");
  property p_drop_together;
    $fell(pins.cs_hv) |-> $fell(pins.vop_en);
  endproperty
  a_drop_together: assert property (p_drop_together)
    else $error("supply not removed with pulse end");
  property p_sense_gap;
    $fell(pins.cs_n) |-> !pins.vop_en && !$past(pins.vop_en, 2);
  endproperty
  a_sense_gap: assert property (p_sense_gap)
    else $error("enable too soon after supply removal");
  property p_one_out;
    pins.vop_en |-> $onehot(pins.vop_sel);
  endproperty
  a_one_out: assert property (p_one_out)
    else $error("supply not on exactly one output");
  property p_addr_hold;
    pins.vop_en && $past(pins.vop_en) |-> $stable(pins.addr);
  endproperty
  a_addr_hold: assert property (p_addr_hold)
    else $error("address moved during pulse cycle");
  property p_fail_quiet;
    stat.fail_link |-> !pins.vop_en && !pins.cs_hv;
  endproperty
  a_fail_quiet: assert property (p_fail_quiet)
    else $error("programming after link failure");
  property p_cool_quiet;
    !pins.pwr_on |-> !pins.vop_en && !pins.cs_hv;
  endproperty
  a_cool_quiet: assert property (p_cool_quiet)
    else $error("programming while supply removed");
  property p_done_once;
    stat.done |-> !stat.busy ##1 !stat.done;
  endproperty
  a_done_once: assert property (p_done_once)
    else $error("done not a single pulse");
endmodule
`default_nettype wire

// file: fpp_prom_model.sv
// behavioural 512 x 8 fuse prom; word 3 bit 2 needs three pulses
// assumes pins from fpp_ctrl; fresh swaps in a blank part, with word 7 bit 7 already blown if pre_blow
`timescale 1ns/1ns
`default_nettype none
module fpp_prom_model (
  input  wire logic                       fresh,
  input  wire logic                       stuck,
  input  wire logic                       pre_blow,
  input  wire fpp_pkg::fpp_pins_s         pins,
  output logic      [fpp_pkg::DATA_W-1:0] prom_data
);
  logic [fpp_pkg::DATA_W-1:0] mem [fpp_pkg::WORDS];
  int                         hits;
  logic [fpp_pkg::ADDR_W-1:0] last_a;
  logic [fpp_pkg::DATA_W-1:0] last_s;
  wire logic                  hv;
  assign hv = pins.cs_hv;
  // deselected or unpowered outputs show the inverted word
  assign prom_data = (pins.pwr_on && !pins.cs_n) ? mem[pins.addr]
                                                 : ~mem[pins.addr];
  always @(posedge fresh or posedge hv) begin
    if (fresh) begin
      foreach (mem[i]) mem[i] = '0;
      if (pre_blow) mem[7][7] = 1'b1;
      hits = 0;
    end else if (pins.vop_en && pins.cs_n && pins.pwr_on) begin
      if (pins.addr != last_a || pins.vop_sel != last_s) hits = 0;
      hits++;
      last_a = pins.addr;
      last_s = pins.vop_sel;
      if (!(stuck && pins.addr == 9'h005) &&
          (hits >= 3 || pins.addr != 9'h003))
        mem[pins.addr] = mem[pins.addr] | pins.vop_sel;
    end
  end
endmodule
`default_nettype wire

// file: fpp_ctrl_tb_top.sv
// testbench top for the fuse prom sequencer
// assumes fpp_ctrl, fpp_prom_model and fpp_ctrl_sva are compiled
`timescale 1ns/1ns
`default_nettype none
module fpp_ctrl_tb_top;
  localparam int FC = 20;
  localparam int RC = 40;
  localparam int LC = 200;
  localparam int BC = 100;
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic        pat_wr = 1'b0;
  logic [8:0]  pat_addr = '0;
  logic [7:0]  pat_data = '0;
  logic        start = 1'b0;
  logic        fresh = 1'b0;
  logic        stuck = 1'b0;
  logic        pre_blow = 1'b0;
  wire logic [7:0] prom_data;
  fpp_pkg::fpp_pins_s pins;
  fpp_pkg::fpp_stat_s stat;
  int          errors = 0;
  int          checks = 0;
  int          cycles = 0;
  int          cool_cyc = 0;
  always #25 clk_sys = ~clk_sys;
  fpp_ctrl #(.FIRST_CYC(FC), .RETRY_CYC(RC), .LIMIT_CYC(LC),
             .BURST_CYC(BC)) dut_u (
    .clk_sys(clk_sys), .rst(rst), .pat_wr(pat_wr), .pat_addr(pat_addr),
    .pat_data(pat_data), .start(start), .prom_data(prom_data),
    .pins(pins), .stat(stat));
  fpp_prom_model prom_u (.fresh(fresh), .stuck(stuck),
    .pre_blow(pre_blow), .pins(pins), .prom_data(prom_data));
  task automatic chk(input string what, input logic [8:0] exp,
                     input logic [8:0] got);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic test_done;
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // cycles with the prom supply removed during a run
  always @(posedge clk_sys) begin
    if (stat.busy && !pins.pwr_on) cool_cyc++;
  end
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 60000) begin
      errors++;
      test_done();
    end
  end
  task automatic new_chip(input logic s, input logic p);
    @(negedge clk_sys);
    stuck = s;
    pre_blow = p;
    fresh = 1'b1;
    @(negedge clk_sys);
    fresh = 1'b0;
  endtask
  task automatic load(input int a0, input logic [7:0] d0, input int a1,
                      input logic [7:0] d1, input int a2, input logic [7:0] d2);
    for (int i = 0; i < 512; i++) begin
      @(negedge clk_sys);
      pat_wr = 1'b1;
      pat_addr = 9'(i);
      pat_data = i == a0 ? d0 : i == a1 ? d1 : i == a2 ? d2 : 8'h00;
    end
    @(negedge clk_sys);
    pat_wr = 1'b0;
  endtask
  task automatic run;
    logic seen;
    seen = 1'b0;
    @(negedge clk_sys);
    start = 1'b1;
    @(negedge clk_sys);
    start = 1'b0;
    chk("busy", 9'h001, 9'(stat.busy));
    for (int i = 0; i < 20000 && !seen; i++) begin
      @(negedge clk_sys);
      seen = stat.done;
    end
    chk("done", 9'h001, 9'(seen));
  endtask
  task automatic sc_program;
    new_chip(1'b0, 1'b0);
    load(0, 8'hA5, 3, 8'h04, 511, 8'h80);
    run();
    chk("fail_link", 9'h000, 9'(stat.fail_link));
    chk("fail_verify", 9'h000, 9'(stat.fail_verify));
    chk("word0", 9'h0A5, 9'(prom_u.mem[0]));
    chk("word3", 9'h004, 9'(prom_u.mem[3]));
    chk("word511", 9'h080, 9'(prom_u.mem[511]));
    chk("word1", 9'h000, 9'(prom_u.mem[1]));
    chk("cool_long", 9'h001, 9'(cool_cyc >= BC));
  endtask
  task automatic sc_stuck;
    new_chip(1'b1, 1'b0);
    load(5, 8'h01, 5, 8'h01, 5, 8'h01);
    run();
    chk("fail_link", 9'h001, 9'(stat.fail_link));
    chk("fail_addr", 9'h005, stat.fail_addr);
    chk("pulses", 9'(1 + (LC - FC + RC - 1) / RC), 9'(prom_u.hits));
  endtask
  task automatic sc_extra;
    new_chip(1'b0, 1'b1);
    load(2, 8'h01, 2, 8'h01, 2, 8'h01);
    run();
    chk("fail_link", 9'h000, 9'(stat.fail_link));
    chk("fail_verify", 9'h001, 9'(stat.fail_verify));
    chk("fail_addr", 9'h007, stat.fail_addr);
  endtask
  initial begin
    repeat (2) @(negedge clk_sys);
    rst = 1'b0;
    sc_program();
    sc_stuck();
    sc_extra();
    test_done();
  end
endmodule
bind fpp_ctrl fpp_ctrl_sva sva_u (.clk_sys(clk_sys), .rst(rst),
  .pat_wr(pat_wr), .pat_addr(pat_addr), .pat_data(pat_data),
  .start(start), .prom_data(prom_data), .pins(pins), .stat(stat));
`default_nettype wire
